// ==== hw/phy_recovery_scramble_path.sv ====
// One channel's clock selection, scrambling, recovery and MLT3 coding.
// Summary of operation
// - Codec bypass forwards 5-bit words unchanged.
// - Codec bypass: carrier sense follows link pass.
// - No valid data: loop tracks transmit clock.
// - 100M copper: switch after squelch and equalizer.
// - 100M recovered nibble clock goes to controller.
// - Fiber: switch to line on signal detect.
// - Sample line bits, assemble into nibbles.
// - 10M: 2.5 MHz clock, switch on squelch.
// - 10M lock under 12 transitions, keep preamble.
// - Scramble at 100M copper only.
// - Each channel scrambler runs independently.
// - Scrambler bypass sends encoder output straight.
// - Descramble and align to 5-bit boundaries.
// - Need 25 idle ones per 1 ms.
// - Loss-of-sync flag while unsynchronised.
// - No descrambling in fiber mode.
// - No descrambling at 10M.
// - Descrambler bypass passes raw received data.
// - MLT3: one steps level, zero holds.
// - 10M idle: silent except link pulses.
// - 10M pulse shaping plays table samples.
// - Codec bypass selects five-bit symbol interface.
`timescale 1ns/1ns
`default_nettype none
`include "prsp_cfg.svh"
module phy_recovery_scramble_path #(
    parameter int         SYNC_WINDOW_CYC =
        `PRSP_SYNC_WINDOW_NS / `PRSP_CORE_PERIOD_NS,
    parameter logic [10:0] SCR_SEED       = `PRSP_SCR_SEED
) (
    // Core clock domain.
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               clkEn,
    // Channel mode from the control logic.
    input  wire prsp_pkg::prsp_mode_t mode,
    // Line status pins.
    input  wire logic               squelchValid,
    input  wire logic               eqSettled,
    input  wire logic               fiber_signal_detect,
    input  wire logic               linkPass,
    // Transmit side from the encoder.
    input  wire logic [4:0]         txCode,
    input  wire logic               txLoad,
    input  wire logic               bitTick,
    input  wire logic               txActive10,
    input  wire logic               linkPulseReq,
    // Twisted pair transmit.
    output logic [1:0]              twisted_pair_line,
    output logic                    tpDriveEn,
    output logic [5:0]              dacSample,
    // Recovery control and status.
    output logic                    refSelLine,
    output logic                    carrierSense,
    output logic                    lossOfSync,
    // Link clock domain.
    input  wire logic               lineClk,
    input  wire logic               lineBit,
    output prsp_pkg::prsp_rxsym_t   rxSym,
    output logic                    rxSymValid,
    output logic                    rxNibbleClk
);
    import prsp_pkg::*;

    localparam int WIN_W = $clog2(SYNC_WINDOW_CYC + 1);
    localparam logic [WIN_W-1:0] WIN_LAST =
        WIN_W'(SYNC_WINDOW_CYC - 1);

    // Pulse shape for 10M transmission; read back by the DAC strobe.
    localparam logic [5:0] PULSE_ROM [`PRSP_ROM_DEPTH] = '{
        6'h08, 6'h18, 6'h28, 6'h30, 6'h2C, 6'h20, 6'h10, 6'h04};

    // Next key bit of the 11-bit stream cipher.
    function automatic logic keyBit(input logic [10:0] l);
        keyBit = l[10] ^ l[`PRSP_LFSR_TAP];
    endfunction

    // Core domain state.
    typedef struct packed {
        logic [1:0]       sqS;
        logic [1:0]       eqS;
        logic [1:0]       fsdS;
        logic [1:0]       linkS;
        logic [1:0]       syncS;
        logic [2:0]       seenS;
        logic [10:0]      scr;
        logic [4:0]       txShift;
        logic [1:0]       mltPhase;
        logic [1:0]       level;
        logic             driveEn;
        logic [1:0]       dacDiv;
        logic [2:0]       romIdx;
        logic [5:0]       dac;
        logic             refSel;
        logic             crs;
        logic             los;
        logic             restartTgl;
        logic [WIN_W-1:0] timer;
        logic             seen;
    } prsp_core_t;

    // Link domain state.
    typedef struct packed {
        logic [1:0]  rstS;
        prsp_mode_t  modeS1;
        prsp_mode_t  modeS2;
        logic [1:0]  sqS;
        logic [2:0]  restartS;
        logic [1:0]  bitS;
        logic [10:0] key;
        logic [4:0]  ones;
        logic [3:0]  loadCnt;
        prsp_dsync_t dstate;
        logic [9:0]  hist;
        logic [2:0]  bitCnt;
        logic [4:0]  shift;
        logic [3:0]  lockCnt;
        logic        locked;
        logic        prevBit;
        logic        seenTgl;
        logic        synced;
        prsp_rxsym_t sym;
        logic        symValid;
        logic        nibClk;
    } prsp_line_t;

    prsp_core_t c_q, c_d;
    prsp_line_t l_q, l_d;
    logic       txPlain;
    logic       txLineBit;
    logic       rxPlain;

    // Transmit path, clock selection and sync supervision.
    always_comb begin
        c_d = c_q;
        c_d.sqS   = {c_q.sqS[0], squelchValid};
        c_d.eqS   = {c_q.eqS[0], eqSettled};
        c_d.fsdS  = {c_q.fsdS[0], fiber_signal_detect};
        c_d.linkS = {c_q.linkS[0], linkPass};
        c_d.syncS = {c_q.syncS[0], l_q.synced};
        c_d.seenS = {c_q.seenS[1:0], l_q.seenTgl};
        // Loop reference: transmit clock unless the line is usable.
        if (mode.fiberMode) begin
            c_d.refSel = c_q.fsdS[1];
        end else if (mode.speed100) begin
            c_d.refSel = c_q.sqS[1] & c_q.eqS[1];
        end else begin
            c_d.refSel = c_q.sqS[1];
        end
        // Carrier sense spans the whole link pass time under bypass.
        c_d.crs = mode.bypassCodec ? c_q.linkS[1]
                                   : c_q.sqS[1];
        c_d.los = ~c_q.syncS[1];
        // Each idle-ones event from the link side refreshes the window.
        if (c_q.seenS[2] != c_q.seenS[1]) begin
            c_d.seen = 1'b1;
        end
        if (!c_q.syncS[1]) begin
            c_d.timer = '0;
            c_d.seen  = 1'b0;
        end else if (c_q.timer == WIN_LAST) begin
            c_d.timer = '0;
            // An event landing on the last cycle counts for the next window.
            c_d.seen  = (c_q.seenS[2] != c_q.seenS[1]);
            if (!c_q.seen && c_q.seenS[2] == c_q.seenS[1]) begin
                c_d.restartTgl = ~c_q.restartTgl;
            end
        end else begin
            c_d.timer = c_q.timer + 1'b1;
        end
        // Serialise encoder words; a load replaces the finished word.
        if (txLoad) begin
            c_d.txShift = txCode;
        end else if (bitTick) begin
            c_d.txShift = {c_q.txShift[3:0], 1'b0};
        end
        if (bitTick) begin
            c_d.scr = {c_q.scr[9:0], keyBit(c_q.scr)};
            if (txLineBit) begin
                c_d.mltPhase = c_q.mltPhase + 1'b1;
            end
        end
        unique case (c_d.mltPhase)
            2'h0:    c_d.level = `PRSP_LVL_PLUS;
            2'h2:    c_d.level = `PRSP_LVL_MINUS;
            default: c_d.level = `PRSP_LVL_ZERO;
        endcase
        // 10M: quiet line between packets apart from link pulses.
        if (mode.speed100) begin
            c_d.driveEn = 1'b1;
        end else begin
            c_d.driveEn = txActive10 | linkPulseReq;
        end
        // The DAC strobe is a divider off the core clock.
        c_d.dacDiv = c_q.dacDiv + 1'b1;
        if (c_q.dacDiv == 2'(`PRSP_DAC_DIV - 1)) begin
            c_d.dacDiv = '0;
        end
        // Silence the DAC at once when idle, not at the next strobe.
        if (!mode.speed100 && c_d.driveEn) begin
            if (c_q.dacDiv == 2'(`PRSP_DAC_DIV - 1)) begin
                c_d.dac    = PULSE_ROM[c_q.romIdx];
                c_d.romIdx = c_q.romIdx + 1'b1;
            end
        end else begin
            c_d.dac    = '0;
            c_d.romIdx = '0;
        end
    end

    // Plain and line bit of the transmitter.
    assign txPlain   = c_q.txShift[4];
    assign txLineBit = (mode.speed100 && !mode.fiberMode
                        && !mode.bypassScrambler)
                       ? txPlain ^ keyBit(c_q.scr)
                       : txPlain;

    // Core domain register; frozen while the clock enable is low.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            c_q          <= '0;
            c_q.scr      <= SCR_SEED;
            // Last zero before plus, so the first one steps to plus.
            c_q.mltPhase <= 2'h3;
            c_q.los      <= 1'b1;
            c_q.driveEn  <= 1'b0;
        end else if (clkEn) begin
            c_q <= c_d;
        end
    end

    // Receive path on the recovered clock.
    always_comb begin
        logic [2:0] symLen;
        logic       useDescr;
        logic       b;
        symLen = l_q.modeS2.speed100 ? `PRSP_SYM_LEN_100
                                     : `PRSP_SYM_LEN_10;
        useDescr = l_q.modeS2.speed100 && !l_q.modeS2.fiberMode
                   && !l_q.modeS2.bypassScrambler;
        b = 1'b0;
        l_d = l_q;
        l_d.rstS     = {l_q.rstS[0], 1'b0};
        l_d.modeS1   = mode;
        l_d.modeS2   = l_q.modeS1;
        l_d.sqS      = {l_q.sqS[0], squelchValid};
        l_d.restartS = {l_q.restartS[1:0], c_q.restartTgl};
        l_d.bitS     = {l_q.bitS[0], lineBit};
        l_d.prevBit  = l_q.bitS[1];
        l_d.symValid = 1'b0;
        b = useDescr ? l_q.bitS[1] ^ keyBit(l_q.key)
                     : l_q.bitS[1];
        // Descrambler key hunt assumes idle, which is all ones.
        unique case (l_q.dstate)
            DS_HUNT: begin
                l_d.key     = {l_q.key[9:0], ~l_q.bitS[1]};
                l_d.loadCnt = l_q.loadCnt + 1'b1;
                l_d.ones    = '0;
                if (l_q.loadCnt == 4'hA) begin
                    l_d.dstate  = DS_CHECK;
                    l_d.loadCnt = '0;
                end
            end
            DS_CHECK: begin
                l_d.key  = {l_q.key[9:0], keyBit(l_q.key)};
                l_d.ones = b ? l_q.ones + 1'b1 : '0;
                if (!b) begin
                    l_d.dstate = DS_HUNT;
                end else if (l_q.ones == 5'(`PRSP_IDLE_ONES - 1)) begin
                    l_d.dstate = DS_SYNCED;
                    l_d.ones   = '0;
                end
            end
            DS_SYNCED: begin
                l_d.key  = {l_q.key[9:0], keyBit(l_q.key)};
                l_d.ones = b ? l_q.ones + 1'b1 : '0;
                if (b && l_q.ones == 5'(`PRSP_IDLE_ONES - 1)) begin
                    // Every full run refreshes the window, even in long idle.
                    l_d.seenTgl = ~l_q.seenTgl;
                    l_d.ones    = '0;
                end
            end
        endcase
        if (l_q.restartS[2] != l_q.restartS[1]) begin
            l_d.dstate  = DS_HUNT;
            l_d.loadCnt = '0;
        end
        l_d.synced = (l_d.dstate == DS_SYNCED) || !useDescr;
        // 10M lock counts line transitions after the squelch opens.
        if (!l_q.sqS[1]) begin
            l_d.lockCnt = '0;
            l_d.locked  = l_q.modeS2.speed100;
        end else if (!l_q.locked && l_q.bitS[1] != l_q.prevBit) begin
            l_d.lockCnt = l_q.lockCnt + 1'b1;
            if (l_q.lockCnt == 4'(`PRSP_LOCK_TRANSITIONS - 1)) begin
                l_d.locked = 1'b1;
            end
        end
        // Assemble words; a /J/K/ pair fixes the word boundary.
        l_d.hist  = {l_q.hist[8:0], b};
        l_d.shift = {l_q.shift[3:0], b};
        if (l_q.locked) begin
            if (l_q.modeS2.speed100 && l_d.hist == `PRSP_JK_PATTERN) begin
                l_d.bitCnt = '0;
                l_d.sym.code = l_d.shift;
                l_d.symValid = 1'b1;
            end else if (l_q.bitCnt == symLen - 3'h1) begin
                l_d.bitCnt   = '0;
                l_d.sym.code = l_q.modeS2.speed100 ? l_d.shift
                               : {1'b0, l_d.shift[3:0]};
                l_d.symValid = 1'b1;
            end else begin
                l_d.bitCnt = l_q.bitCnt + 1'b1;
            end
        end else begin
            l_d.bitCnt = '0;
        end
        l_d.sym.fiveBitMode = l_q.modeS2.bypassCodec;
        // Nibble clock is high through the first two bits of each word.
        l_d.nibClk = (l_d.bitCnt < (symLen >> 1));
    end

    // Link domain register; its reset release is delayed through two flops.
    always_ff @(posedge lineClk) begin
        if (reset) begin
            l_q        <= '0;
            l_q.rstS   <= 2'h3;
            l_q.dstate <= DS_HUNT;
        end else if (l_q.rstS[1]) begin
            l_q        <= '0;
            l_q.rstS   <= {l_q.rstS[0], 1'b0};
            l_q.dstate <= DS_HUNT;
        end else begin
            l_q <= l_d;
        end
    end

    // Outputs straight from flops.
    assign twisted_pair_line = c_q.level;
    assign tpDriveEn         = c_q.driveEn;
    assign dacSample         = c_q.dac;
    assign refSelLine        = c_q.refSel;
    assign carrierSense      = c_q.crs;
    assign lossOfSync        = c_q.los;
    assign rxSym             = l_q.sym;
    assign rxSymValid        = l_q.symValid;
    assign rxNibbleClk       = l_q.nibClk;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Fiber reference follows signal detect.
    ref_fiber_a: assert property (clkEn && mode.fiberMode
        |=> refSelLine == $past(c_q.fsdS[1]))
        else $error("fiber reference select wrong");
    // Without squelch the loop stays on the transmit clock.
    ref_idle_a: assert property (clkEn && !mode.fiberMode
        && !c_q.sqS[1] |=> !refSelLine)
        else $error("reference left transmit clock without data");
    // 100M copper needs the equalizer before switching.
    ref_eq_a: assert property (clkEn && mode.speed100
        && !mode.fiberMode && !c_q.eqS[1] |=> !refSelLine)
        else $error("switched before equalizer settled");
    // Loss flag tracks the synchronised status three flops later.
    los_flag_a: assert property (clkEn && !l_q.synced
        ##1 clkEn && !c_q.syncS[0] ##1 clkEn |=> lossOfSync)
        else $error("loss of sync flag not set");
    // Codec bypass carrier sense follows link pass.
    crs_bypass_a: assert property (clkEn && mode.bypassCodec
        && c_q.linkS[1] |=> carrierSense)
        else $error("carrier dropped in link pass under bypass");
    // 10M idle line is silent.
    tx10_quiet_a: assert property (clkEn && !mode.speed100
        && !txActive10 && !linkPulseReq |=> !tpDriveEn && dacSample == '0)
        else $error("10M idle line driven");
    // A zero holds the MLT3 level, a one moves it.
    mlt_hold_a: assert property (clkEn && !txLoad && bitTick
        && !txLineBit |=> $stable(twisted_pair_line))
        else $error("MLT3 level moved on a zero");
    mlt_step_a: assert property (clkEn && bitTick && txLineBit
        |=> $changed(twisted_pair_line))
        else $error("MLT3 level held on a one");
    // Bypass sends the encoder bit unscrambled.
    scr_bypass_a: assert property (mode.bypassScrambler
        |-> txLineBit == c_q.txShift[4])
        else $error("scrambler not bypassed");
    // A silent window forces reacquisition.
    sync_restart_a: assert property (clkEn && c_q.syncS[1]
        && c_q.timer == WIN_LAST && !c_q.seen
        && c_q.seenS[2] == c_q.seenS[1]
        |=> c_q.restartTgl != $past(c_q.restartTgl))
        else $error("descrambler not restarted after silent window");
endmodule // phy_recovery_scramble_path
`default_nettype wire

// ==== hw/prsp_cfg.svh ====
// Constants for the recovery, scrambling and line coding data path.
`ifndef PRSP_CFG_SVH
`define PRSP_CFG_SVH
`define PRSP_CORE_PERIOD_NS   10
`define PRSP_SYNC_WINDOW_NS   1000000
`define PRSP_IDLE_ONES        25
`define PRSP_LOCK_TRANSITIONS 11
`define PRSP_LFSR_TAP         8
`define PRSP_SCR_SEED         11'h5A3
`define PRSP_JK_PATTERN       10'h311
`define PRSP_SYM_LEN_100      3'h5
`define PRSP_SYM_LEN_10       3'h4
`define PRSP_DAC_DIV          2
`define PRSP_ROM_DEPTH        8
`define PRSP_LVL_PLUS         2'h1
`define PRSP_LVL_ZERO         2'h0
`define PRSP_LVL_MINUS        2'h3
`endif

// ==== hw/prsp_pkg.sv ====
// Types shared by the recovery, scrambling and line coding data path.
package prsp_pkg;
    // Channel mode settings, quasi-static while traffic flows.
    typedef struct packed {
        logic speed100;
        logic fiberMode;
        logic bypassCodec;
        logic bypassScrambler;
    } prsp_mode_t;

    // Descrambler acquisition states.
    typedef enum logic [2:0] {
        DS_HUNT   = 3'b001,
        DS_CHECK  = 3'b010,
        DS_SYNCED = 3'b100
    } prsp_dsync_t;

    // Receive symbol towards the decoder or the controller.
    typedef struct packed {
        logic [4:0] code;
        logic       fiveBitMode;
    } prsp_rxsym_t;
endpackage

// ==== verif/prsp_line_src.sv ====
// Line-side transmitter model that feeds the receive path bit by bit.
`timescale 1ns/1ns
`default_nettype none
module prsp_line_src (
    // Recovered bit clock.
    input  wire logic lineClk,
    // Received line bit towards the design.
    output logic      lineBit
);
    logic [10:0] scr;
    logic        busy;

    // Start with a nonzero key state so the keystream never sticks at zero.
    initial begin
        scr = 11'h7FF;
        busy = 1'b0;
        lineBit = 1'b0;
    end

    // Between frames the line toggles, so no stale bit looks like data.
    always @(posedge lineClk) begin
        if (!busy) begin
            lineBit <= ~lineBit;
        end
    end

    // Send n bits of w, MSB first, optionally scrambled with the key.
    task automatic send(input logic [4:0] w, input int n, input logic sc);
        logic b;
        busy = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge lineClk);
            b = w[i] ^ (sc & (scr[10] ^ scr[8]));
            scr = {scr[9:0], scr[10] ^ scr[8]};
            lineBit <= b;
        end
        busy = 1'b0;
    endtask
endmodule // prsp_line_src
`default_nettype wire

// ==== verif/phy_recovery_scramble_path_tb.sv ====
// Self-checking bench for the recovery, scrambling and MLT3 data path.
`timescale 1ns/1ns
`default_nettype none
module phy_recovery_scramble_path_tb;
    import prsp_pkg::*;
    logic core_clk, reset, clkEn, lineClk, lineBit;
    logic squelchValid, eqSettled, fsd, linkPass;
    logic txLoad, bitTick, txActive10, linkPulseReq;
    logic tpDriveEn, refSelLine, carrierSense, lossOfSync;
    logic rxSymValid, rxNibbleClk;
    logic [4:0] txCode;
    logic [1:0] tpLine, lastLvl;
    logic [5:0] dacSample;
    prsp_mode_t  mode;
    prsp_rxsym_t rxSym;
    prsp_rxsym_t rq [$];
    logic [31:0] rngState = 32'h9088568B;
    logic [1:0]  lvlTab [4] = '{2'h0, 2'h1, 2'h0, 2'h3};
    int miscompares = 0;
    int samplesChecked = 0;
    int changes;

    phy_recovery_scramble_path #(.SYNC_WINDOW_CYC(200)) dut (
        .core_clk(core_clk), .reset(reset), .clkEn(clkEn), .mode(mode),
        .squelchValid(squelchValid), .eqSettled(eqSettled),
        .fiber_signal_detect(fsd), .linkPass(linkPass),
        .txCode(txCode), .txLoad(txLoad), .bitTick(bitTick),
        .txActive10(txActive10), .linkPulseReq(linkPulseReq),
        .twisted_pair_line(tpLine), .tpDriveEn(tpDriveEn),
        .dacSample(dacSample), .refSelLine(refSelLine),
        .carrierSense(carrierSense), .lossOfSync(lossOfSync),
        .lineClk(lineClk), .lineBit(lineBit), .rxSym(rxSym),
        .rxSymValid(rxSymValid), .rxNibbleClk(rxNibbleClk));

    prsp_line_src src (.lineClk(lineClk), .lineBit(lineBit));

    // Core clock at 100 MHz.
    always #5 core_clk = ~core_clk;

    // Link clock, offset so its edges never meet the core rising edge.
    initial begin
        lineClk = 1'b0;
        #2;
        forever #24 lineClk = ~lineClk;
    end

    // Count every level step on the line, independent of its latency.
    always @(posedge core_clk) begin
        if (reset) begin
            changes = 0;
            lastLvl = 2'h0;
        end else if (tpLine !== lastLvl) begin
            changes++;
            lastLvl = tpLine;
        end
    end

    // Collect every received word for later comparison.
    always @(posedge lineClk) begin
        if (rxSymValid === 1'b1) rq.push_back(rxSym);
    end

    // Repeatable xorshift source for random stimulus.
    function automatic logic [31:0] rnd();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    // Which input the recovery loop should follow.
    function automatic logic expRef(prsp_mode_t m, logic sq, eq, sd);
        if (m.fiberMode) return sd;
        if (m.speed100) return sq & eq;
        return sq;
    endfunction

    task automatic checkBit(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic checkVec(input logic [5:0] got, input logic [5:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    // Load one word, then shift it out with five back-to-back ticks.
    task automatic txWord(input logic [4:0] w);
        @(negedge core_clk);
        txLoad = 1'b1;
        txCode = w;
        @(negedge core_clk);
        txLoad = 1'b0;
        bitTick = 1'b1;
        repeat (5) @(negedge core_clk);
        bitTick = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic sendMany(input int n, input logic idle, input logic sc);
        for (int i = 0; i < n; i++) src.send(idle ? 5'h1F : 5'(rnd()), 5, sc);
        repeat (20) @(negedge core_clk);
    endtask

    task automatic endOfTest();
        $display("Checked %0d, miscompares %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // The whole run should end well inside this span.
    initial begin
        #150000;
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        endOfTest();
    end

    // Main sequence.
    initial begin
        logic [4:0]  wd;
        logic [4:0]  d [6];
        logic [31:0] r;
        int ones;
        int c0;
        int k;
        logic seen;
        core_clk = 1'b0;
        reset = 1'b1;
        clkEn = 1'b1;
        mode = 4'b1001;
        {squelchValid, eqSettled, fsd, linkPass} = 4'h0;
        {txLoad, bitTick, txActive10, linkPulseReq} = 4'h0;
        txCode = 5'h00;
        // Long enough for both domains to see reset.
        repeat (5) @(posedge lineClk);
        @(negedge core_clk);
        checkVec({4'h0, tpLine}, 6'h00);
        checkBit(lossOfSync, 1'b1);
        checkBit(refSelLine, 1'b0);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        // Plain MLT3 with the scrambler bypassed: all ones, all zeros, random.
        ones = 0;
        for (int w = 0; w < 8; w++) begin
            wd = (w == 0) ? 5'h1F : (w == 1) ? 5'h00 : 5'(rnd());
            ones += $countones(wd);
            txWord(wd);
            checkVec(6'(changes), 6'(ones));
            checkVec({4'h0, tpLine}, {4'h0, lvlTab[ones % 4]});
        end
        // Scrambled ones cannot give a step on every bit.
        mode = 4'b1000;
        c0 = changes;
        for (int w = 0; w < 4; w++) txWord(5'h1F);
        checkBit((changes - c0) < 20, 1'b1);
        checkBit(tpDriveEn, 1'b1);
        // 10M idle stays silent; a link pulse plays the shaping table.
        mode = 4'b0000;
        repeat (6) @(negedge core_clk);
        checkVec(dacSample, 6'h00);
        checkBit(tpDriveEn, 1'b0);
        linkPulseReq = 1'b1;
        seen = 1'b0;
        repeat (20) @(negedge core_clk) seen |= (dacSample != 6'h00);
        checkBit(seen, 1'b1);
        linkPulseReq = 1'b0;
        // Recovery reference and carrier sense over random status pins.
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            mode = {r[0] | r[1], r[1], r[2], 1'b1};
            squelchValid = r[3];
            eqSettled = r[4];
            fsd = r[5];
            linkPass = r[6];
            repeat (5) @(negedge core_clk);
            checkBit(refSelLine, expRef(mode, r[3], r[4], r[5]));
            checkBit(carrierSense, mode.bypassCodec ? r[6] : r[3]);
        end
        // Five-bit words pass unchanged, aligned on the start delimiter.
        mode = 4'b1011;
        squelchValid = 1'b1;
        eqSettled = 1'b1;
        repeat (10) @(posedge lineClk);
        rq.delete();
        for (int i = 0; i < 3; i++) src.send(5'h1F, 5, 1'b0);
        src.send(5'h18, 5, 1'b0);
        src.send(5'h11, 5, 1'b0);
        for (int i = 0; i < 6; i++) begin
            d[i] = 5'(rnd());
            src.send(d[i], 5, 1'b0);
        end
        for (int i = 0; i < 3; i++) src.send(5'h1F, 5, 1'b0);
        k = -1;
        for (int i = 1; i < rq.size(); i++)
            if (k < 0 && rq[i].code === 5'h11) k = i;
        checkBit(k > 0 && k + 6 < rq.size(), 1'b1);
        for (int i = 0; i < 6 && k > 0 && k + 6 < rq.size(); i++)
            checkVec(rq[k + 1 + i], {d[i], 1'b1});
        // 10M preamble: enough nibbles survive the locking time.
        mode = 4'b0000;
        squelchValid = 1'b0;
        repeat (10) @(posedge lineClk);
        rq.delete();
        squelchValid = 1'b1;
        repeat (4) @(posedge lineClk);
        for (int i = 0; i < 14; i++) src.send(5'h0A, 4, 1'b0);
        checkBit(rq.size() >= 6, 1'b1);
        foreach (rq[i]) checkBit(rq[i].code inside {5'h0A, 5'h05}, 1'b1);
        squelchValid = 1'b0;
        // Descrambler: noise loses sync, idle regains and keeps it.
        mode = 4'b1000;
        sendMany(30, 1'b0, 1'b1);
        checkBit(lossOfSync, 1'b1);
        sendMany(12, 1'b1, 1'b1);
        checkBit(lossOfSync, 1'b0);
        sendMany(12, 1'b1, 1'b1);
        checkBit(lossOfSync, 1'b0);
        sendMany(30, 1'b0, 1'b1);
        checkBit(lossOfSync, 1'b1);
        mode = 4'b1100;
        repeat (30) @(negedge core_clk);
        checkBit(lossOfSync, 1'b0);
        endOfTest();
    end
endmodule // phy_recovery_scramble_path_tb
`default_nettype wire
